// >>> evw_defs.svh
`ifndef EVW_DEFS_SVH
`define EVW_DEFS_SVH
// What this block does
// - suspend-ack pin edges go up at 40h bit0
// - mux pin function follows role level continuously
// - primary: mux pin shows 41h bit1 wire
// - primary: host reset ack only as 6h bit3
// - secondary: mux pin rises after warn, once idle
// - secondary: never answer host reset warn upstream
// - secondary: ignore suspend power-down wire
// - chip select gates down writes and PC accept, not up takes
// - peripheral channel: host I/O and memory only
// - four wires per index, fixed direction each
// - down wires 2h, 3h, 41h, default zero
// - up wires 4h default 11x0, 5h 0000
// - 6h default 0111; 6h/7h on platform reset
// - 40h bit1 reserved wire, default zero
// - primary sends boot done and status as one
// - warn pin follows wire; secondary ignores ack pin

`define EVW_IDX_SLEEP 8'h02
`define EVW_IDX_RSTS 8'h03
`define EVW_IDX_OOB 8'h04
`define EVW_IDX_BOOT 8'h05
`define EVW_IDX_HOST 8'h06
`define EVW_IDX_HWARN 8'h07
`define EVW_IDX_SUSUP 8'h40
`define EVW_IDX_SUSDN 8'h41

`define EVW_DEF_DN 4'h0
`define EVW_DEF_OOB 4'hc
`define EVW_DEF_BOOT 4'h0
`define EVW_DEF_HOST 4'h7
`define EVW_DEF_SUSUP 4'h0

`define EVW_MASK_SLEEP 4'h7
`define EVW_MASK_RSTS 4'h7
`define EVW_MASK_HWARN 4'h1
`define EVW_MASK_SUSDN 4'hb

`define EVW_BIT_SUSPEND_ACK_IN_N 0
`define EVW_BIT_PWRDN 1
`define EVW_BIT_SWARN 0
`define EVW_BIT_HRACK 3
`define EVW_BIT_SLPA 3

`define EVW_CT_IO_RD 4'h0
`define EVW_CT_IO_WR 4'h1
`define EVW_CT_MEM_RD 4'h2
`define EVW_CT_MEM_WR 4'h3

`define EVW_QDEPTH 8
`define EVW_QCW 4
`endif

// >>> evw_master_model.sv
module evw_master_model (
  output logic o_espi_clk,
  output logic o_dn_tgl,
  output logic [7:0] o_dn_index,
  output logic [3:0] o_dn_data,
  output logic o_up_take_tgl
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_espi_clk = 1'h0;
    o_dn_tgl = 1'h0;
    o_dn_index = 8'h00;
    o_dn_data = 4'h0;
    o_up_take_tgl = 1'h0;
  end
  // link clock stands still between frames; 48 ns keeps it under 50 MHz
  task automatic frame;
    #24 o_espi_clk = 1'h1;
    #24 o_espi_clk = 1'h0;
  endtask
  // only wire writes, never config access mid-run
  task automatic wr(input logic [7:0] idx, input logic [3:0] d);
    o_dn_index = idx;
    o_dn_data = d;
    o_dn_tgl = ~o_dn_tgl;
    frame;
    o_dn_data = ~d; // released data must not look held
    #24;
  endtask
  task automatic take;
    o_up_take_tgl = ~o_up_take_tgl;
    frame;
    #24;
  endtask
endmodule // evw_master_model

// >>> evw_pkg.sv
package evw_pkg;
  typedef logic [7:0] evw_idx_t;
  typedef logic [3:0] evw_nib_t;
  typedef enum logic [1:0] {
    EVW_HRA_IDLE,
    EVW_HRA_WAIT,
    EVW_HRA_HIGH
  } evw_hra_e;
endpackage

// >>> evw_vw_sideband.sv
`include "evw_defs.svh"
module evw_vw_sideband (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_espi_clk,
  input wire logic i_espi_rst_n,
  input wire logic i_plt_rst_n,
  input wire logic i_role_sel,
  input wire logic i_suspend_ack_in_n,
  input wire logic i_dn_cs_n,
  input wire logic i_dn_tgl,
  input wire logic [7:0] i_dn_index,
  input wire logic [3:0] i_dn_data,
  input wire logic i_up_take_tgl,
  input wire logic [3:0] i_pc_cycle,
  input wire logic i_host_reset_ack,
  input wire logic i_lpc_idle,
  input wire logic i_sirq_idle,
  input wire logic i_oob_reset_grant,
  input wire logic i_wake_n,
  input wire logic i_pme_n,
  input wire logic i_fatal_error_wire,
  input wire logic i_nonfatal_error_wire,
  input wire logic i_sci_n,
  input wire logic i_smi_n,
  input wire logic i_keyboard_reset_wire,
  output logic o_up_avail,
  output logic [7:0] o_up_index,
  output logic [3:0] o_up_data,
  output logic [2:0] o_sleep_wires,
  output logic o_suspend_status_wire,
  output logic o_platform_reset_wire,
  output logic o_oob_reset_notice,
  output logic o_sleep_a_wire,
  output logic o_suspend_warn_out_n,
  output logic o_suspend_powerdown_grant,
  output logic o_pc_accept
);
  localparam int SW = 24;
  localparam int DEPTH = `EVW_QDEPTH;

  // direction and implemented bits per index
  function automatic logic [3:0] dn_mask(input evw_pkg::evw_idx_t idx);
    case (idx)
      `EVW_IDX_SLEEP: dn_mask = `EVW_MASK_SLEEP;
      `EVW_IDX_RSTS: dn_mask = `EVW_MASK_RSTS;
      `EVW_IDX_HWARN: dn_mask = `EVW_MASK_HWARN;
      `EVW_IDX_SUSDN: dn_mask = `EVW_MASK_SUSDN;
      default: dn_mask = 4'h0;
    endcase
  endfunction

  function automatic logic pc_allowed(input logic [3:0] ct);
    pc_allowed = (ct == `EVW_CT_IO_RD) || (ct == `EVW_CT_IO_WR) ||
                 (ct == `EVW_CT_MEM_RD) || (ct == `EVW_CT_MEM_WR);
  endfunction

  // the link, both resets, role and suspend-ack pin pass two flops; the other sideband pins are used unsynchronized
  logic [SW-1:0] sy1_r;
  logic [SW-1:0] sy2_r;
  wire [SW-1:0] sy_in = {i_espi_clk, i_espi_rst_n, i_plt_rst_n, i_role_sel,
                         i_suspend_ack_in_n, i_dn_cs_n, i_dn_tgl, i_dn_index,
                         i_dn_data, i_up_take_tgl, i_pc_cycle};
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sy1_r <= '0;
      sy2_r <= '0;
    end
    else
    begin
      sy1_r <= sy_in;
      sy2_r <= sy1_r;
    end
  end

  wire lclk_s = sy2_r[23];
  wire espi_rst_act = ~sy2_r[22];
  wire plt_rst_act = ~sy2_r[21];
  wire primary = sy2_r[20];
  wire suspend_ack_in_n_s = sy2_r[19];
  wire cs_n_s = sy2_r[18];
  wire dn_tgl_s = sy2_r[17];
  wire [7:0] dn_idx_s = sy2_r[16:9];
  wire [3:0] dn_dat_s = sy2_r[8:5];
  wire up_tgl_s = sy2_r[4];
  wire [3:0] pc_s = sy2_r[3:0];

  // link fields launch on the falling edge, so they are settled here
  logic lclk_d_r;
  logic dn_seen_r;
  logic up_seen_r;
  wire lclk_rise = lclk_s & ~lclk_d_r;
  wire dn_evt = lclk_rise & (dn_tgl_s != dn_seen_r);
  wire take_evt = lclk_rise & (up_tgl_s != up_seen_r);
  wire [3:0] dn_m = dn_mask(dn_idx_s);
  wire dn_ok = dn_evt & ~cs_n_s & (dn_m != 4'h0);
  wire [3:0] dn_val = dn_dat_s & dn_m;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lclk_d_r <= 1'b0;
      dn_seen_r <= 1'b0;
      up_seen_r <= 1'b0;
    end
    else
    begin
      lclk_d_r <= lclk_s;
      if (lclk_rise)
      begin
        dn_seen_r <= dn_tgl_s;
        up_seen_r <= up_tgl_s;
      end
    end
  end

  // downstream wires
  logic [3:0] dn2_r;
  logic [3:0] dn3_r;
  logic [3:0] dn7_r;
  logic [3:0] dn41_r;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dn2_r <= `EVW_DEF_DN;
      dn3_r <= `EVW_DEF_DN;
      dn41_r <= `EVW_DEF_DN;
    end
    else if (espi_rst_act)
    begin
      dn2_r <= `EVW_DEF_DN;
      dn3_r <= `EVW_DEF_DN;
      dn41_r <= `EVW_DEF_DN;
    end
    else if (dn_ok)
    begin
      if (dn_idx_s == `EVW_IDX_SLEEP)
        dn2_r <= dn_val;
      if (dn_idx_s == `EVW_IDX_RSTS)
        dn3_r <= dn_val;
      if (dn_idx_s == `EVW_IDX_SUSDN)
        dn41_r <= dn_val;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      dn7_r <= `EVW_DEF_DN;
    else if (plt_rst_act)
      dn7_r <= `EVW_DEF_DN;
    else if (dn_ok && dn_idx_s == `EVW_IDX_HWARN)
      dn7_r <= dn_val;
  end

  // secondary role host reset ack pin
  evw_pkg::evw_hra_e hra_r;
  evw_pkg::evw_hra_e hra_nxt;
  logic warn_d_r;
  wire warn = dn7_r[0];
  always_comb
  begin
    hra_nxt = hra_r;
    unique case (hra_r)
      evw_pkg::EVW_HRA_IDLE:
        if (~primary && warn && ~warn_d_r)
          hra_nxt = evw_pkg::EVW_HRA_WAIT;
      evw_pkg::EVW_HRA_WAIT:
        if (~warn)
          hra_nxt = evw_pkg::EVW_HRA_IDLE;
        else if (i_lpc_idle && i_sirq_idle)
          hra_nxt = evw_pkg::EVW_HRA_HIGH;
      evw_pkg::EVW_HRA_HIGH:
        if (~warn)
          hra_nxt = evw_pkg::EVW_HRA_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hra_r <= evw_pkg::EVW_HRA_IDLE;
      warn_d_r <= 1'b0;
    end
    else
    begin
      hra_r <= plt_rst_act ? evw_pkg::EVW_HRA_IDLE : hra_nxt;
      warn_d_r <= warn;
    end
  end

  // pin outputs; the mux re-evaluates role every cycle, never latched
  wire mux_sel = primary ? dn41_r[`EVW_BIT_PWRDN] :
                 (hra_r == evw_pkg::EVW_HRA_HIGH);
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_suspend_powerdown_grant <= 1'b0;
      o_suspend_warn_out_n <= 1'b0;
      o_pc_accept <= 1'b0;
    end
    else
    begin
      o_suspend_powerdown_grant <= mux_sel;
      o_suspend_warn_out_n <= dn41_r[`EVW_BIT_SWARN];
      o_pc_accept <= ~cs_n_s & pc_allowed(pc_s);
    end
  end

  assign o_sleep_wires = dn2_r[2:0];
  assign o_suspend_status_wire = dn3_r[0];
  assign o_platform_reset_wire = dn3_r[1];
  assign o_oob_reset_notice = dn3_r[2];
  assign o_sleep_a_wire = dn41_r[`EVW_BIT_SLPA];

  // upstream wire values and last queued copies
  logic [3:0] sh4_r;
  logic [3:0] sh5_r;
  logic [3:0] sh6_r;
  logic [3:0] sh40_r;
  wire boot = primary;
  wire [3:0] up4 = {i_pme_n, i_wake_n, 1'b0, i_oob_reset_grant};
  wire [3:0] up5 = {boot, i_nonfatal_error_wire, i_fatal_error_wire, boot};
  wire hrack = primary & i_host_reset_ack;
  wire [3:0] up6 = {hrack, i_keyboard_reset_wire, i_smi_n, i_sci_n};
  wire ack_v = primary ? suspend_ack_in_n_s : sh40_r[0];
  wire [3:0] up40 = {3'b000, ack_v};
  // 6h is held at default through platform reset, so nothing is queued
  wire [3:0] diff = {up40 != sh40_r, (up6 != sh6_r) & ~plt_rst_act,
                     up5 != sh5_r, up4 != sh4_r};

  // one push a cycle, fixed priority; a blocked change waits its turn
  logic [`EVW_QCW-1:0] cnt_r;
  wire pop = take_evt & (cnt_r != '0);
  wire room = (cnt_r != `EVW_QCW'(DEPTH)) | pop;
  wire push = (diff != 4'h0) & room & ~espi_rst_act;
  wire [7:0] push_idx = diff[0] ? `EVW_IDX_OOB :
                        diff[1] ? `EVW_IDX_BOOT :
                        diff[2] ? `EVW_IDX_HOST : `EVW_IDX_SUSUP;
  wire [3:0] push_dat = diff[0] ? up4 : diff[1] ? up5 :
                        diff[2] ? up6 : up40;
  wire [`EVW_QCW-1:0] wr_pos = pop ? cnt_r - `EVW_QCW'(1) : cnt_r;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sh4_r <= `EVW_DEF_OOB;
      sh5_r <= `EVW_DEF_BOOT;
      sh40_r <= `EVW_DEF_SUSUP;
      sh6_r <= `EVW_DEF_HOST;
    end
    else
    begin
      if (espi_rst_act)
      begin
        sh4_r <= `EVW_DEF_OOB;
        sh5_r <= `EVW_DEF_BOOT;
        sh40_r <= `EVW_DEF_SUSUP;
      end
      else if (push)
      begin
        if (push_idx == `EVW_IDX_OOB)
          sh4_r <= push_dat;
        if (push_idx == `EVW_IDX_BOOT)
          sh5_r <= push_dat;
        if (push_idx == `EVW_IDX_SUSUP)
          sh40_r <= push_dat;
      end
      if (plt_rst_act)
        sh6_r <= `EVW_DEF_HOST;
      else if (push && push_idx == `EVW_IDX_HOST)
        sh6_r <= push_dat;
    end
  end

  logic [7:0] q_idx_r [DEPTH];
  logic [3:0] q_dat_r [DEPTH];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_slot
      wire [7:0] up_i = (g < DEPTH - 1) ? q_idx_r[(g + 1) % DEPTH] : 8'h00;
      wire [3:0] up_d = (g < DEPTH - 1) ? q_dat_r[(g + 1) % DEPTH] : 4'h0;
      wire here = push & (wr_pos == `EVW_QCW'(g));
      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          q_idx_r[g] <= 8'h00;
          q_dat_r[g] <= 4'h0;
        end
        else if (here)
        begin
          q_idx_r[g] <= push_idx;
          q_dat_r[g] <= push_dat;
        end
        else if (pop)
        begin
          q_idx_r[g] <= up_i;
          q_dat_r[g] <= up_d;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      cnt_r <= '0;
    else if (espi_rst_act)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + `EVW_QCW'(push) - `EVW_QCW'(pop);
  end

  assign o_up_avail = (cnt_r != '0);
  assign o_up_index = q_idx_r[0];
  assign o_up_data = q_dat_r[0];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_ack_rise;
    primary && !espi_rst_act && $rose(suspend_ack_in_n_s) && cnt_r < 4'd4 && !take_evt;
  endsequence
  sequence s_ack_sent;
    push && push_idx == `EVW_IDX_SUSUP && push_dat[0];
  endsequence
  chk_suspend_ack_in_n_edge_up: assert property (
    s_ack_rise |-> ##[0:4] s_ack_sent)
    else $error("suspend ack edge not queued");
  chk_mux_primary_pin: assert property (
    primary |=> o_suspend_powerdown_grant == $past(dn41_r[1]))
    else $error("mux pin does not follow power-down wire");
  chk_mux_secondary_pin: assert property (
    (!primary && hra_r == evw_pkg::EVW_HRA_WAIT && !plt_rst_act)
      |=> !o_suspend_powerdown_grant)
    else $error("mux pin rose before interfaces idle");
  chk_no_host_answer: assert property (
    (push && push_idx == `EVW_IDX_HOST && !primary) |-> !push_dat[3])
    else $error("secondary answered host reset warn");
  chk_other_slave_quiet: assert property (
    (dn_evt && cs_n_s && !espi_rst_act && !plt_rst_act)
      |=> $stable(dn2_r) && $stable(dn41_r) && $stable(dn7_r))
    else $error("traffic for another slave changed state");
  chk_pc_subset_only: assert property (
    o_pc_accept |-> pc_allowed($past(pc_s)))
    else $error("unsupported peripheral cycle accepted");
  chk_boot_wires_low: assert property (
    (push && push_idx == `EVW_IDX_BOOT && !primary)
      |-> push_dat[0] == 1'b0 && push_dat[3] == 1'b0)
    else $error("boot done sent while secondary");
  chk_warn_pin_follow: assert property (
    ##1 o_suspend_warn_out_n == $past(dn41_r[0]))
    else $error("warn pin differs from wire");
  chk_queue_no_loss: assert property (
    (cnt_r == 4'd8 && !pop) |-> !push)
    else $error("push into full queue");
endmodule // evw_vw_sideband

// >>> testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0, i_rst = 1'h1, role = 1'h0, sack_n = 1'h0;
  logic cs_n = 1'h1, lpc_idle = 1'h0, sirq_idle = 1'h0, hra = 1'h0;
  logic ern = 1'h1, prn = 1'h1;
  logic [7:0] lv = 8'he6;
  logic [3:0] pcc = 4'h0;
  logic ek, dtg, ttg, avail, st, pr, oob, sa, wn, gr, acc, sec_g;
  logic [7:0] dix, uix;
  logic [3:0] ddt, udt, r2, r3, r41, sh[4];
  logic [2:0] slp;
  logic [11:0] eq[$];
  int miscompares = 0, n_compared = 0, seed = 32'h38b69480, i;
  always #2.5 i_clk = ~i_clk;
  evw_master_model m (.o_espi_clk(ek), .o_dn_tgl(dtg), .o_dn_index(dix),
    .o_dn_data(ddt), .o_up_take_tgl(ttg));
  evw_vw_sideband i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_espi_clk(ek),
    .i_espi_rst_n(ern), .i_plt_rst_n(prn), .i_role_sel(role),
    .i_suspend_ack_in_n(sack_n), .i_dn_cs_n(cs_n), .i_dn_tgl(dtg),
    .i_dn_index(dix), .i_dn_data(ddt), .i_up_take_tgl(ttg),
    .i_pc_cycle(pcc), .i_host_reset_ack(hra), .i_lpc_idle(lpc_idle),
    .i_sirq_idle(sirq_idle), .i_oob_reset_grant(lv[0]), .i_wake_n(lv[1]),
    .i_pme_n(lv[2]), .i_fatal_error_wire(lv[3]),
    .i_nonfatal_error_wire(lv[4]), .i_sci_n(lv[5]), .i_smi_n(lv[6]),
    .i_keyboard_reset_wire(lv[7]), .o_up_avail(avail), .o_up_index(uix),
    .o_up_data(udt), .o_sleep_wires(slp), .o_suspend_status_wire(st),
    .o_platform_reset_wire(pr), .o_oob_reset_notice(oob),
    .o_sleep_a_wire(sa), .o_suspend_warn_out_n(wn),
    .o_suspend_powerdown_grant(gr), .o_pc_accept(acc));
  task w(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task give_verdict;
    $display("compared %0d wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task cmp_pin(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_up(input logic [11:0] got);
    logic [11:0] e;
    e = eq.size() > 0 ? eq.pop_front() : 12'hfff;
    n_compared++;
    if (got !== e)
    begin
      miscompares++;
      $display("wrong value at %0t got %h exp %h", $time, got, e);
    end
  endtask
  // live up groups, pushed in fixed priority when they differ
  task upd;
    logic [3:0] g[4];
    logic [7:0] ix[4];
    g = '{{lv[2], lv[1], 1'h0, lv[0]}, {role, lv[4], lv[3], role},
      {hra & role, lv[7:5]}, {3'h0, role ? sack_n : sh[3][0]}};
    ix = '{8'h04, 8'h05, 8'h06, 8'h40};
    for (int k = 0; k < 4; k++)
      if (g[k] !== sh[k])
      begin
        eq.push_back({ix[k], g[k]});
        sh[k] = g[k];
      end
  endtask
  task drain(input string name);
    w(8);
    repeat (9)
      if (avail === 1'h1)
      begin
        cmp_up({uix, udt});
        m.take;
        w(4);
      end
    cmp_pin({avail, eq.size() == 0}, 9'h001);
    $display("test %0s done", name);
  endtask
  task check_pins;
    cmp_pin({slp, st, pr, oob, sa, wn, gr}, {r2[2:0], r3[0], r3[1], r3[2],
      r41[3], r41[0], role ? r41[1] : sec_g});
  endtask
  task wrd(input logic [7:0] idx, input logic [3:0] d);
    m.wr(idx, d);
    if (cs_n === 1'h0 && idx == 8'h02) r2 = d & 4'h7;
    if (cs_n === 1'h0 && idx == 8'h03) r3 = d & 4'h7;
    if (cs_n === 1'h0 && idx == 8'h41) r41 = d & 4'hb;
    w(6);
    check_pins;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    give_verdict;
  end
  initial
  begin
    r2 = 4'h0;
    r3 = 4'h0;
    r41 = 4'h0;
    sec_g = 1'h0;
    sh = '{4'hc, 4'h0, 4'h7, 4'h0};
    w(20);
    i_rst = 1'h0;
    w(5);
    cs_n = 1'h0;
    drain("boot_low");
    sack_n = 1'h1;
    upd;
    w(4);
    sack_n = 1'h0;
    upd;
    drain("ack_ignored");
    wrd(8'h07, 4'h1);
    lpc_idle = 1'h1;
    sirq_idle = 1'h1;
    w(4);
    sec_g = 1'h1;
    check_pins;
    wrd(8'h41, 4'h2);
    hra = 1'h1;
    upd;
    drain("warn_no_answer");
    hra = 1'h0;
    sec_g = 1'h0;
    wrd(8'h07, 4'h0);
    role = 1'h1;
    upd;
    drain("role_rise");
    // nine edges overfill the queue by one, the last must wait
    for (i = 0; i < 9; i++)
    begin
      sack_n = ~sack_n;
      upd;
      w(3);
    end
    drain("ack_edges");
    hra = 1'h1;
    upd;
    drain("host_ack");
    check_pins;
    for (i = 0; i < 8; i++)
    begin
      cs_n = (i == 7);
      wrd(i % 3 == 2 ? 8'h41 : 8'(i % 3 + 2), 4'($random(seed)));
    end
    $display("test dn_writes done");
    cs_n = 1'h0;
    for (i = 0; i < 4; i++)
    begin
      lv = 8'($random(seed));
      upd;
      drain("up_groups");
    end
    prn = 1'h0;
    w(4);
    prn = 1'h1;
    sh[2] = 4'h7;
    upd;
    drain("plt_reset");
    ern = 1'h0;
    w(4);
    ern = 1'h1;
    r2 = 4'h0;
    r3 = 4'h0;
    r41 = 4'h0;
    sh[0] = 4'hc;
    sh[1] = 4'h0;
    sh[3] = 4'h0;
    upd;
    drain("espi_reset");
    check_pins;
    for (i = 0; i < 9; i++)
    begin
      cs_n = (i == 8);
      pcc = 4'($random(seed));
      w(5);
      cmp_pin(acc, !cs_n && pcc < 4'h4);
    end
    $display("test pc_cycles done");
    give_verdict;
  end
endmodule // testbench
